//--- shared/sync_ctl_defs.vh
// register offsets, field positions and reset values of the sync/clamp bank
`ifndef SYNC_CTL_DEFS_VH
`define SYNC_CTL_DEFS_VH

`define OFS_IF_CTL        8'h0F
`define OFS_SYNC_CTL      8'h10
`define OFS_CLAMP_CTL     8'h11
`define OFS_STATUS        8'h15

`define RST_IF_CTL        8'h78
`define RST_SYNC_CTL      8'h40
`define RST_CLAMP_CTL     8'h0A

`define BIT_IF_OVR        2
`define BIT_IF_SEL        1
`define BIT_HS_POL_OVR    7
`define BIT_HS_POL        6
`define BIT_HS_OUT_POL    5
`define BIT_HS_OVR        4
`define BIT_HS_SEL        3
`define BIT_VS_OUT_POL    2
`define BIT_VS_OVR        1
`define BIT_VS_SEL        0
`define BIT_CLAMP_OFF     7
`define BIT_RED_MID       6
`define BIT_GREEN_MID     5

`define ST_HS_DET         7
`define ST_SOG_DET        6
`define ST_VS_DET         5
`define ST_DIG_DET        4
`define ST_IF_DIG         3
`define ST_HS_SOG         2
`define ST_VS_SEP         1
`define ST_HS_POL         0

`define DEV_ADDR          7'h4C
`define PLACE_MIN         8'h01

`endif

//--- design/serial_ctl_slave.v
// two-wire serial control port slave with sub-address auto-increment
`timescale 1ns/1ns
`default_nettype none
`include "sync_ctl_defs.vh"

module serial_ctl_slave #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       scl_pin,
	input  wire       sda_pin_in,
	input  wire [7:0] rd_data,
	output reg  [7:0] ptr_q,
	output reg        wr_en_q,
	output reg  [7:0] wr_data_q,
	output reg        sda_out_q,
	output reg        sda_oe_n_q
);

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_DEV  = 3'd1;
	localparam [2:0] S_ACK  = 3'd2;
	localparam [2:0] S_SUB  = 3'd3;
	localparam [2:0] S_WR   = 3'd4;
	localparam [2:0] S_RD   = 3'd5;
	localparam [2:0] S_RACK = 3'd6;

	reg [2:0] scl_s;
	reg [2:0] sda_s;
	reg [2:0] st_q;
	reg [2:0] nxt_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg       nack_q;

	// only stages 1 and 2 are looked at; stage 0 is the metastable one
	wire rise  = scl_s[1] & ~scl_s[2];
	wire fall  = ~scl_s[1] & scl_s[2];
	wire start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	wire stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

	always @(posedge core_clk) begin
		scl_s <= {scl_s[1:0], scl_pin};
		sda_s <= {sda_s[1:0], sda_pin_in};
		wr_en_q <= 1'b0;
		sda_out_q <= 1'b0;
		if (rst) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			st_q <= S_IDLE;
			nxt_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			nack_q <= 1'b0;
			ptr_q <= 8'h00;
			wr_data_q <= 8'h00;
			sda_oe_n_q <= 1'b1;
		end else if (start) begin
			st_q <= S_DEV;
			cnt_q <= 4'h0;
			sda_oe_n_q <= 1'b1;
		end else if (stop) begin
			st_q <= S_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			case (st_q)
			S_DEV, S_SUB, S_WR: begin
				if (rise && cnt_q != 4'h8) begin
					sh_q <= {sh_q[6:0], sda_s[1]};
					cnt_q <= cnt_q + 4'h1;
				end else if (fall && cnt_q == 4'h8) begin
					cnt_q <= 4'h0;
					sda_oe_n_q <= 1'b0;
					st_q <= S_ACK;
					if (st_q == S_DEV) begin
						nxt_q <= sh_q[0] ? S_RD : S_SUB;
						if (sh_q[7:1] != DEV_ADDR) begin
							sda_oe_n_q <= 1'b1;
							st_q <= S_IDLE;
						end
					end else if (st_q == S_SUB) begin
						ptr_q <= sh_q;
						nxt_q <= S_WR;
					end else begin
						wr_en_q <= 1'b1;
						wr_data_q <= sh_q;
						nxt_q <= S_WR;
					end
				end
			end
			S_ACK: begin
				if (fall) begin
					st_q <= nxt_q;
					sda_oe_n_q <= 1'b1;
					if (nxt_q == S_RD) begin
						sh_q <= {rd_data[6:0], 1'b0};
						sda_oe_n_q <= rd_data[7];
						cnt_q <= 4'h1;
					end
				end
			end
			S_RD: begin
				if (fall) begin
					if (cnt_q == 4'h8) begin
						sda_oe_n_q <= 1'b1;
						ptr_q <= ptr_q + 8'h01;
						st_q <= S_RACK;
					end else begin
						sda_oe_n_q <= sh_q[7];
						sh_q <= {sh_q[6:0], 1'b0};
						cnt_q <= cnt_q + 4'h1;
					end
				end
			end
			S_RACK: begin
				if (rise)
					nack_q <= sda_s[1];
				else if (fall) begin
					if (nack_q)
						st_q <= S_IDLE;
					else begin
						sh_q <= {rd_data[6:0], 1'b0};
						sda_oe_n_q <= rd_data[7];
						cnt_q <= 4'h1;
						st_q <= S_RD;
					end
				end
			end
			default: st_q <= S_IDLE;
			endcase
			// the write pulse leaves the state machine already in the ack phase
			if (st_q == S_ACK && wr_en_q)
				ptr_q <= ptr_q + 8'h01;
		end
	end

endmodule

`default_nettype wire

//--- design/hsync_edge_unit.v
// hsync polarity detection, edge selection and internal clamp timing
`timescale 1ns/1ns
`default_nettype none
`include "sync_ctl_defs.vh"

module hsync_edge_unit #(
	parameter CW = 12
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       hs_in,
	input  wire       pol_ovr,
	input  wire       pol_bit,
	input  wire       clamp_off,
	input  wire       pix_en,
	input  wire [7:0] placement,
	input  wire [7:0] duration,
	output reg        pol_eff_q,
	output reg        lead_q,
	output reg        clamp_q
);

	reg          hs_d;
	reg          det_pol_q;
	reg [CW-1:0] hi_q;
	reg [CW-1:0] lo_q;
	reg [1:0]    ph_q;
	reg [7:0]    cnt_q;

	wire rise  = hs_in & ~hs_d;
	wire fall  = ~hs_in & hs_d;
	wire trail = pol_eff_q ? fall : rise;
	wire [CW-1:0] top = {CW{1'b1}};

	always @(posedge core_clk) begin
		// tracks the pin through reset, so no false edge follows release
		hs_d <= hs_in;
		if (rst) begin
			det_pol_q <= 1'b1;
			hi_q <= {CW{1'b0}};
			lo_q <= {CW{1'b0}};
			pol_eff_q <= 1'b1;
			lead_q <= 1'b0;
		end else begin
			// the shorter of the two levels is the sync pulse
			if (rise) begin
				det_pol_q <= hi_q < lo_q;
				hi_q <= {{(CW-1){1'b0}}, 1'b1};
				lo_q <= {CW{1'b0}};
			end else if (hs_in) begin
				if (hi_q != top)
					hi_q <= hi_q + {{(CW-1){1'b0}}, 1'b1};
			end else if (lo_q != top)
				lo_q <= lo_q + {{(CW-1){1'b0}}, 1'b1};
			pol_eff_q <= pol_ovr ? pol_bit : det_pol_q;
			lead_q <= pol_eff_q ? rise : fall;
		end
	end

	always @(posedge core_clk) begin
		if (rst || clamp_off) begin
			ph_q <= 2'd0;
			cnt_q <= 8'h00;
			clamp_q <= 1'b0;
		end else begin
			clamp_q <= ph_q == 2'd2;
			if (trail) begin
				ph_q <= 2'd1;
				// placement 0 is outside the legal range, run it as 1
				cnt_q <= (placement < `PLACE_MIN) ? `PLACE_MIN : placement;
			end else if (pix_en) begin
				case (ph_q)
				2'd1: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01) begin
						ph_q <= (duration == 8'h00) ? 2'd0 : 2'd2;
						cnt_q <= duration;
					end
				end
				2'd2: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01)
						ph_q <= 2'd0;
				end
				default: ph_q <= 2'd0;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

//--- design/sync_source_and_clamp_control.v
// sync source, polarity and clamp control bank behind the serial port
//
// How it works
// - interface override clear: automatic interface choice; set: select bit decides.
// - interface select: 0 analog, 1 digital; breaks ties when both active.
// - hsync polarity override clear: detected polarity; set: polarity bit used.
// - polarity bit 0 active low, 1 active high; pll uses leading edge.
// - clamp timing starts from the trailing hsync edge.
// - after reset polarity bit reads 1, its override reads 0.
// - hsync output polarity: 0 drives pulse high, 1 drives pulse low.
// - hsync source override clear: automatic; set: hsync select bit decides.
// - hsync select: 0 hsync pin, 1 green sync; breaks ties when both active.
// - vsync output polarity: 1 passes vsync straight, 0 inverts it.
// - vsync source override clear: automatic; set: vsync select decides.
// - under vsync override: 0 vsync pin, 1 sync separator output.
// - clamp function 0 runs internal clamp timing, 1 disables it.
// - red clamp select: 0 ground, 1 midscale; default 0.
// - green clamp select: 0 ground, 1 midscale; default 0.
// - clamp starts placement pixel periods after trailing edge, 1 to 255.
`timescale 1ns/1ns
`default_nettype none
`include "sync_ctl_defs.vh"

module sync_source_and_clamp_control #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR,
	parameter       POL_CW   = 12
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       scl_pin,
	input  wire       sda_pin_in,
	output wire       sda_out,
	output wire       sda_oe_n,
	input  wire       hsync_pin,
	input  wire       green_embedded_sync,
	input  wire       vsync_pin,
	input  wire       sep_vsync,
	input  wire       hsync_activity,
	input  wire       sog_activity,
	input  wire       vsync_activity,
	input  wire       digital_clk_activity,
	input  wire       pixel_en,
	input  wire [7:0] clamp_placement,
	input  wire [7:0] clamp_duration,
	output reg        active_digital_q,
	output reg        hsync_from_sog_q,
	output reg        vsync_from_sep_q,
	output reg        hsync_out_q,
	output reg        sog_out_q,
	output reg        vsync_out_q,
	output wire       pll_lead_edge,
	output wire       clamp_active,
	output reg        red_clamp_mid_q,
	output reg        green_clamp_mid_q,
	output reg        blue_clamp_mid_q,
	output reg  [4:0] slicer_threshold_q
);

	reg  [7:0] if_ctl_q;
	reg  [7:0] sync_ctl_q;
	reg  [7:0] clamp_ctl_q;
	reg  [7:0] rd_data;
	reg  [1:0] hs_sync_q;
	reg  [1:0] sog_sync_q;
	reg  [1:0] vs_sync_q;
	reg        hs_sel_d;
	reg        vs_sel_d;
	reg        if_sel_d;

	wire [7:0] ptr;
	wire       wr_en;
	wire [7:0] wr_data;
	wire       pol_eff;
	wire       hs_raw;
	wire       hs_norm;
	wire       sog_norm;
	wire       vs_raw;
	wire       analog_act;

	// tie-break helper shared by the three automatic choices
	function pick;
		input ovr;
		input sel;
		input act0;
		input act1;
		begin
			if (ovr)
				pick = sel;
			else if (act0 && !act1)
				pick = 1'b0;
			else if (act1 && !act0)
				pick = 1'b1;
			else
				pick = sel;
		end
	endfunction

	serial_ctl_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_port (
		.core_clk   (core_clk),
		.rst        (rst),
		.scl_pin    (scl_pin),
		.sda_pin_in (sda_pin_in),
		.rd_data    (rd_data),
		.ptr_q      (ptr),
		.wr_en_q    (wr_en),
		.wr_data_q  (wr_data),
		.sda_out_q  (sda_out),
		.sda_oe_n_q (sda_oe_n)
	);

	// register writes; reserved addresses swallow the data
	always @(posedge core_clk) begin
		if (rst) begin
			if_ctl_q <= `RST_IF_CTL;
			sync_ctl_q <= `RST_SYNC_CTL;
			clamp_ctl_q <= `RST_CLAMP_CTL;
		end else if (wr_en) begin
			case (ptr)
			`OFS_IF_CTL:    if_ctl_q <= wr_data;
			`OFS_SYNC_CTL:  sync_ctl_q <= wr_data;
			`OFS_CLAMP_CTL: clamp_ctl_q <= wr_data;
			default:        if_ctl_q <= if_ctl_q;
			endcase
		end
	end

	always @* begin
		case (ptr)
		`OFS_IF_CTL:    rd_data = if_ctl_q;
		`OFS_SYNC_CTL:  rd_data = sync_ctl_q;
		`OFS_CLAMP_CTL: rd_data = clamp_ctl_q;
		`OFS_STATUS: begin
			rd_data = 8'h00;
			rd_data[`ST_HS_DET] = hsync_activity;
			rd_data[`ST_SOG_DET] = sog_activity;
			rd_data[`ST_VS_DET] = vsync_activity;
			rd_data[`ST_DIG_DET] = digital_clk_activity;
			rd_data[`ST_IF_DIG] = active_digital_q;
			rd_data[`ST_HS_SOG] = hsync_from_sog_q;
			rd_data[`ST_VS_SEP] = vsync_from_sep_q;
			rd_data[`ST_HS_POL] = pol_eff;
		end
		default:        rd_data = 8'h00;
		endcase
	end

	// pins come from outside the clock domain; not reset, so the
	// synchronisers already hold the idle level when reset ends
	always @(posedge core_clk) begin
		hs_sync_q <= {hs_sync_q[0], hsync_pin};
		sog_sync_q <= {sog_sync_q[0], green_embedded_sync};
		vs_sync_q <= {vs_sync_q[0], vsync_pin};
	end

	assign analog_act = hsync_activity | sog_activity;

	always @* begin
		if_sel_d = pick(if_ctl_q[`BIT_IF_OVR], if_ctl_q[`BIT_IF_SEL],
			analog_act, digital_clk_activity);
		hs_sel_d = pick(sync_ctl_q[`BIT_HS_OVR], sync_ctl_q[`BIT_HS_SEL],
			hsync_activity, sog_activity);
		// automatic vsync: the pin when it toggles, else the separator
		vs_sel_d = pick(sync_ctl_q[`BIT_VS_OVR], sync_ctl_q[`BIT_VS_SEL],
			vsync_activity, ~vsync_activity);
	end

	// the unit sees the chosen hsync; a wrong polarity moves the clamp and the pll edge and inverts the hsync outputs
	assign hs_raw = hsync_from_sog_q ? sog_sync_q[1] : hs_sync_q[1];
	assign vs_raw = vsync_from_sep_q ? sep_vsync : vs_sync_q[1];

	hsync_edge_unit #(
		.CW (POL_CW)
	) u_edge (
		.core_clk  (core_clk),
		.rst       (rst),
		.hs_in     (hs_raw),
		.pol_ovr   (sync_ctl_q[`BIT_HS_POL_OVR]),
		.pol_bit   (sync_ctl_q[`BIT_HS_POL]),
		.clamp_off (clamp_ctl_q[`BIT_CLAMP_OFF]),
		.pix_en    (pixel_en),
		.placement (clamp_placement),
		.duration  (clamp_duration),
		.pol_eff_q (pol_eff),
		.lead_q    (pll_lead_edge),
		.clamp_q   (clamp_active)
	);

	// active-high view of the sync pulses, whatever their input polarity
	assign hs_norm = pol_eff ? hs_raw : ~hs_raw;
	assign sog_norm = pol_eff ? sog_sync_q[1] : ~sog_sync_q[1];

	always @(posedge core_clk) begin
		if (rst) begin
			active_digital_q <= 1'b0;
			hsync_from_sog_q <= 1'b0;
			vsync_from_sep_q <= 1'b0;
			hsync_out_q <= 1'b0;
			sog_out_q <= 1'b0;
			vsync_out_q <= 1'b1;
			red_clamp_mid_q <= 1'b0;
			green_clamp_mid_q <= 1'b0;
			blue_clamp_mid_q <= 1'b0;
			slicer_threshold_q <= 5'h0F;
		end else begin
			active_digital_q <= if_sel_d;
			hsync_from_sog_q <= hs_sel_d;
			vsync_from_sep_q <= vs_sel_d;
			hsync_out_q <= hs_norm ^ sync_ctl_q[`BIT_HS_OUT_POL];
			sog_out_q <= sog_norm ^ sync_ctl_q[`BIT_HS_OUT_POL];
			vsync_out_q <= vs_raw ^ ~sync_ctl_q[`BIT_VS_OUT_POL];
			red_clamp_mid_q <= clamp_ctl_q[`BIT_RED_MID];
			green_clamp_mid_q <= clamp_ctl_q[`BIT_GREEN_MID];
			blue_clamp_mid_q <= clamp_ctl_q[4];
			slicer_threshold_q <= if_ctl_q[7:3];
		end
	end

endmodule

`default_nettype wire

//--- verif/video_source_model.sv
// far-side video source: periodic hsync lines and pixel enables
`timescale 1ns/1ns
`default_nettype none

module video_source_model (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic line_en,
	input  wire logic active_high,
	output logic      hsync_pin,
	output logic      pixel_en
);
	logic [5:0] pos_q;

	always @(posedge core_clk) begin
		pos_q <= rst ? 6'h00 : pos_q + 6'h01;
		pixel_en <= pos_q[0];
		// 64-cycle line, pulse in the first 8; idle level when stopped
		hsync_pin <= (line_en && pos_q < 6'h08) ~^ active_high;
	end
endmodule
`default_nettype wire

//--- verif/sync_ctl_checker.sv
// port-level assertions for the sync source and clamp control bank
`timescale 1ns/1ns
`default_nettype none

module sync_ctl_checker (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       scl_pin,
	input wire logic       hsync_pin,
	input wire logic       green_embedded_sync,
	input wire logic       vsync_pin,
	input wire logic       sep_vsync,
	input wire logic       hsync_activity,
	input wire logic       sog_activity,
	input wire logic       vsync_activity,
	input wire logic       digital_clk_activity,
	input wire logic [7:0] clamp_duration,
	input wire logic       active_digital_q,
	input wire logic       hsync_from_sog_q,
	input wire logic       vsync_from_sep_q,
	input wire logic       hsync_out_q,
	input wire logic       vsync_out_q,
	input wire logic       pll_lead_edge,
	input wire logic       clamp_active,
	input wire logic       red_clamp_mid_q,
	input wire logic       green_clamp_mid_q
);
	logic [8:0] prv_q;
	logic [7:0] hs_a_q;
	logic [7:0] vs_a_q;
	logic [7:0] cf_a_q;
	wire  [8:0] cur = {scl_pin, hsync_pin, green_embedded_sync, vsync_pin,
		sep_vsync, hsync_activity, sog_activity, vsync_activity,
		digital_clk_activity};

	function automatic logic [7:0] inc(input logic [7:0] a);
		inc = (a == 8'hFF) ? a : a + 8'h01;
	endfunction

	// cycles since each possible cause last moved; 0 throughout reset
	always @(posedge core_clk) begin
		prv_q <= cur;
		hs_a_q <= (rst || cur[7:6] != prv_q[7:6]) ? 8'h00 : inc(hs_a_q);
		vs_a_q <= (rst || cur[5:4] != prv_q[5:4]) ? 8'h00 : inc(vs_a_q);
		cf_a_q <= (rst || cur[8] != prv_q[8] || cur[3:0] != prv_q[3:0]) ?
			8'h00 : inc(cf_a_q);
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_reset_defaults: assert property (disable iff (1'b0) rst |=>
		!active_digital_q && !hsync_from_sog_q && !red_clamp_mid_q &&
		!green_clamp_mid_q && !clamp_active && vsync_out_q)
		else $error("outputs not at reset values");
	a_iface_cause: assert property ($changed(active_digital_q) |->
		cf_a_q <= 8'h0C) else $error("interface moved without cause");
	a_hsel_cause: assert property ($changed(hsync_from_sog_q) |->
		cf_a_q <= 8'h0C) else $error("hsync source moved without cause");
	a_vsel_cause: assert property ($changed(vsync_from_sep_q) |->
		cf_a_q <= 8'h0C) else $error("vsync source moved without cause");
	a_hout_cause: assert property ($changed(hsync_out_q) |->
		hs_a_q <= 8'h08 || cf_a_q <= 8'h0C)
		else $error("hsync output moved without cause");
	a_vout_cause: assert property ($changed(vsync_out_q) |->
		vs_a_q <= 8'h08 || cf_a_q <= 8'h0C)
		else $error("vsync output moved without cause");
	a_lead_single: assert property (pll_lead_edge |=> !pll_lead_edge)
		else $error("leading edge pulse too long");
	a_lead_cause: assert property (pll_lead_edge |->
		hs_a_q <= 8'h08 || cf_a_q <= 8'h0C)
		else $error("leading edge pulse without hsync edge");
	a_clamp_after: assert property ($rose(clamp_active) |->
		hs_a_q >= 8'h03 && clamp_duration != 8'h00)
		else $error("clamp started too early");
	a_mid_cause: assert property ($changed({red_clamp_mid_q,
		green_clamp_mid_q}) |-> cf_a_q <= 8'h0C)
		else $error("clamp select moved without write");

	c_clamp: cover property ($rose(clamp_active));
	c_lead: cover property (pll_lead_edge);
	c_digital: cover property ($rose(active_digital_q));
endmodule

bind sync_source_and_clamp_control sync_ctl_checker sync_ctl_checker_i (
	.core_clk(core_clk), .rst(rst), .scl_pin(scl_pin),
	.hsync_pin(hsync_pin), .green_embedded_sync(green_embedded_sync),
	.vsync_pin(vsync_pin), .sep_vsync(sep_vsync),
	.hsync_activity(hsync_activity), .sog_activity(sog_activity),
	.vsync_activity(vsync_activity),
	.digital_clk_activity(digital_clk_activity),
	.clamp_duration(clamp_duration), .active_digital_q(active_digital_q),
	.hsync_from_sog_q(hsync_from_sog_q), .vsync_from_sep_q(vsync_from_sep_q),
	.hsync_out_q(hsync_out_q), .vsync_out_q(vsync_out_q),
	.pll_lead_edge(pll_lead_edge), .clamp_active(clamp_active),
	.red_clamp_mid_q(red_clamp_mid_q), .green_clamp_mid_q(green_clamp_mid_q));
`default_nettype wire

//--- verif/tb_sync_source_and_clamp_control.sv
// self-checking bench for the sync source and clamp control bank
`timescale 1ns/1ns
`default_nettype none
`include "sync_ctl_defs.vh"

module tb_sync_source_and_clamp_control;
	logic       core_clk = 1'b0;
	logic       rst      = 1'b1;
	logic       scl      = 1'b1;
	logic       sda_m    = 1'b1;
	logic       gsync    = 1'b0;
	logic       vsync    = 1'b0;
	logic       sep      = 1'b0;
	logic [3:0] act      = 4'h0;
	logic       line_en  = 1'b0;
	logic       act_high = 1'b0;
	logic [7:0] nl;
	logic [7:0] nc;
	int         bad_count = 0;
	int         n_checks  = 0;
	wire        sda_out, sda_oe_n, hs_pin, pix, dig, from_sog, from_sep;
	wire        hs_out, vs_out, lead, clamp, red_mid, green_mid;
	// open-drain data line with pull-up
	wire        sda_w = sda_m & (sda_oe_n | sda_out);

	always #5 core_clk = ~core_clk;

	video_source_model video_source_model_i (.core_clk(core_clk), .rst(rst),
		.line_en(line_en), .active_high(act_high), .hsync_pin(hs_pin),
		.pixel_en(pix));

	sync_source_and_clamp_control sync_source_and_clamp_control_i (
		.core_clk(core_clk), .rst(rst), .scl_pin(scl), .sda_pin_in(sda_w),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .hsync_pin(hs_pin),
		.green_embedded_sync(gsync), .vsync_pin(vsync), .sep_vsync(sep),
		.hsync_activity(act[3]), .sog_activity(act[2]),
		.vsync_activity(act[1]), .digital_clk_activity(act[0]),
		.pixel_en(pix), .clamp_placement(8'h02), .clamp_duration(8'h03),
		.active_digital_q(dig), .hsync_from_sog_q(from_sog),
		.vsync_from_sep_q(from_sep), .hsync_out_q(hs_out), .sog_out_q(),
		.vsync_out_q(vs_out), .pll_lead_edge(lead), .clamp_active(clamp),
		.red_clamp_mid_q(red_mid), .green_clamp_mid_q(green_mid),
		.blue_clamp_mid_q(), .slicer_threshold_q());

	task automatic hc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string what);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// data moves only while the clock line is low
	task automatic bitx(input logic b, output logic r);
		sda_m <= b;
		hc(4);
		scl <= 1'b1;
		hc(4);
		@(negedge core_clk);
		r = sda_w;
		hc(4);
		scl <= 1'b0;
		hc(4);
	endtask

	task automatic xfer(input logic [7:0] b, input logic ack_exp);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r);
		bitx(1'b1, r);
		chk({7'h00, ~r}, {7'h00, ack_exp}, "ack");
	endtask

	task automatic start;
		sda_m <= 1'b1;
		hc(4);
		scl <= 1'b1;
		hc(8);
		sda_m <= 1'b0;
		hc(8);
		scl <= 1'b0;
		hc(4);
	endtask

	task automatic stop;
		sda_m <= 1'b0;
		hc(4);
		scl <= 1'b1;
		hc(8);
		sda_m <= 1'b1;
		hc(8);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		start;
		xfer({`DEV_ADDR, 1'b0}, 1'b1);
		xfer(a, 1'b1);
		xfer(d, 1'b1);
		stop;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       r;
		start;
		xfer({`DEV_ADDR, 1'b0}, 1'b1);
		xfer(a, 1'b1);
		start;
		xfer({`DEV_ADDR, 1'b1}, 1'b1);
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(1'b1, r);
		stop;
		chk(d, exp, "register read");
	endtask

	// act order: hsync, green sync, vsync, digital clock
	task automatic sel_case(input logic [7:0] a, input logic [7:0] v,
			input logic [3:0] acts, input int idx, input logic e);
		wr_reg(a, v);
		act <= acts;
		hc(4);
		chk({7'h00, idx == 0 ? dig : idx == 1 ? from_sog : from_sep},
			{7'h00, e}, "source select");
	endtask

	task automatic pol_case(input logic [7:0] v, input logic he,
			input logic ve);
		wr_reg(8'h10, v);
		hc(4);
		chk({6'h00, hs_out, vs_out}, {6'h00, he, ve}, "output polarity");
	endtask

	task automatic window(output logic [7:0] l, output logic [7:0] c);
		l = 8'h00;
		c = 8'h00;
		for (int i = 0; i < 128; i++) begin
			@(negedge core_clk);
			l += {7'h00, lead};
			c += {7'h00, clamp};
		end
	endtask

	initial begin
		hc(90000);
		bad_count++;
		finish_test;
	end

	initial begin
		hc(5);
		rst <= 1'b0;
		hc(3);
		rd_reg(8'h0F, 8'h78);
		rd_reg(8'h10, 8'h40);
		rd_reg(8'h11, 8'h0A);
		rd_reg(8'h20, 8'h00);
		start;
		xfer({`DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
		stop;
		sel_case(8'h0F, 8'h78, 4'h1, 0, 1'b1);
		sel_case(8'h0F, 8'h78, 4'h9, 0, 1'b0);
		sel_case(8'h0F, 8'h7A, 4'h9, 0, 1'b1);
		sel_case(8'h0F, 8'h7C, 4'h1, 0, 1'b0);
		sel_case(8'h0F, 8'h7E, 4'h8, 0, 1'b1);
		sel_case(8'h10, 8'h40, 4'h4, 1, 1'b1);
		sel_case(8'h10, 8'h40, 4'hC, 1, 1'b0);
		sel_case(8'h10, 8'h48, 4'hC, 1, 1'b1);
		sel_case(8'h10, 8'h50, 4'h4, 1, 1'b0);
		sel_case(8'h10, 8'h58, 4'h8, 1, 1'b1);
		sel_case(8'h10, 8'h43, 4'h2, 2, 1'b1);
		sel_case(8'h10, 8'h42, 4'h0, 2, 1'b0);
		sel_case(8'h10, 8'h40, 4'h2, 2, 1'b0);
		rd_reg(8'h0F, 8'h7E);
		act <= 4'h8;
		vsync <= 1'b1;
		pol_case(8'hC2, 1'b1, 1'b0);
		pol_case(8'hE6, 1'b0, 1'b1);
		pol_case(8'h82, 1'b0, 1'b0);
		pol_case(8'hA6, 1'b1, 1'b1);
		wr_reg(8'h10, 8'hC0);
		act_high <= 1'b1;
		line_en <= 1'b1;
		hc(128);
		window(nl, nc);
		chk(nl, 8'h02, "leading edges per two lines");
		chk({7'h00, nc != 8'h00}, 8'h01, "clamp running");
		wr_reg(8'h11, 8'h8A);
		hc(64);
		window(nl, nc);
		chk(nc, 8'h00, "clamp disabled");
		wr_reg(8'h11, 8'h4A);
		hc(4);
		chk({6'h00, red_mid, green_mid}, 8'h02, "red midscale");
		wr_reg(8'h11, 8'h2A);
		hc(4);
		chk({6'h00, red_mid, green_mid}, 8'h01, "green midscale");
		rd_reg(8'h11, 8'h2A);
		rd_reg(8'h15, 8'h8B);
		finish_test;
	end
endmodule
`default_nettype wire
